// *** hdl/fdc_drive_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module fdc_drive_control_regs (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic [9:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rd_data_out,
   input wire fdc_pkg::fdc_mode_t mode_in,
   input wire logic enhanced_floppy_mode_2_in,
   input wire logic drive_swap_in,
   input wire logic [7:0] drive_type_config_reg_in,
   input wire logic [1:0] boot_drive_in,
   input wire logic [7:0] main_status_in,
   output fdc_pkg::fdc_drive_pins_t drive_pins_out,
   output logic dma_irq_gate_out,
   output logic soft_reset_low_out,
   output logic low_power_out,
   output logic [1:0] data_rate_out,
   output logic [2:0] precomp_sel_out,
   output logic [1:0] tape_drive_out,
   output logic tape_selected_out
);

   // ==========================================================
   // State
   fdc_pkg::fdc_state_t state_reg;
   fdc_pkg::fdc_state_t state_next;

   logic wr_dor;
   logic wr_tdr;
   logic wr_dsr;
   logic wr_ccr;
   logic rd_dor;
   logic rd_tdr;
   logic rd_msr;
   logic data_access;
   logic soft_start;
   logic soft_active;
   logic [7:0] dor_new;
   logic [1:0] sel;
   logic motor0;
   logic motor1;
   logic [7:0] tdr_view;
   logic [2:0] type_idx;
   logic [1:0] type_id;

   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      wr_dor = wr_in && (addr_in == fdc_pkg::ADDR_DOR);
      wr_tdr = wr_in && (addr_in == fdc_pkg::ADDR_TDR);
      wr_dsr = wr_in && (addr_in == fdc_pkg::ADDR_DSR);
      wr_ccr = wr_in && (addr_in == fdc_pkg::ADDR_CCR);
      rd_dor = rd_in && (addr_in == fdc_pkg::ADDR_DOR);
      rd_tdr = rd_in && (addr_in == fdc_pkg::ADDR_TDR);
      rd_msr = rd_in && (addr_in == fdc_pkg::ADDR_DSR);
      data_access = (rd_in || wr_in) && (addr_in == fdc_pkg::ADDR_DATA);

      // Output-control register; a reset entry also drops the gating bit
      dor_new = state_reg.drive_output_control;
      if (wr_dor) begin
         dor_new = wr_data_in;
      end
      soft_start = (wr_dor && !wr_data_in[fdc_pkg::DOR_SOFT_RESET_LOW_BIT]) ||
                   (wr_dsr && wr_data_in[fdc_pkg::DSR_SWRESET_BIT]);
      if (soft_start) begin
         dor_new[fdc_pkg::DOR_DMA_BIT] = 1'h0;
      end
      state_next.drive_output_control = dor_new;

      // Tape register only ever changes by a write or hardware reset
      if (wr_tdr) begin
         state_next.tape = wr_data_in[1:0];
      end

      // Rate bits come from whichever register was written last
      if (wr_dsr) begin
         state_next.rate = wr_data_in[fdc_pkg::DSR_RATE_LSB +: 2];
         state_next.precomp = wr_data_in[fdc_pkg::DSR_PRECOMP_LSB +: 3];
      end else if (wr_ccr) begin
         state_next.rate = wr_data_in[fdc_pkg::CCR_RATE_LSB +: 2];
      end

      // Self-clearing reset is stretched to the minimum reset width
      if (wr_dsr && wr_data_in[fdc_pkg::DSR_SWRESET_BIT]) begin
         state_next.stretch = fdc_pkg::SOFT_RESET_CYCLES;
      end else if (state_reg.stretch != 2'h0) begin
         state_next.stretch = state_reg.stretch - 2'h1;
      end
      soft_active = !dor_new[fdc_pkg::DOR_SOFT_RESET_LOW_BIT] ||
                    (state_next.stretch != 2'h0);
      state_next.soft_reset_low = !soft_active;

      // Any reset or data-path access wakes the controller up
      if (soft_active || rd_msr || data_access) begin
         state_next.low_power = 1'h0;
      end else if (wr_dsr && wr_data_in[fdc_pkg::DSR_POWER_BIT]) begin
         state_next.low_power = 1'h1;
      end

      // Second-generation mode ignores the gating bit
      state_next.dma_irq_gate = (mode_in == fdc_pkg::FDC_MODE_SECOND_GEN) ||
                                dor_new[fdc_pkg::DOR_DMA_BIT];

      // Pin decode from the freshly updated register, bits 6 and 7 unused
      sel = dor_new[fdc_pkg::DOR_SEL_LSB +: 2];
      motor0 = dor_new[fdc_pkg::DOR_MOTOR0_BIT];
      motor1 = dor_new[fdc_pkg::DOR_MOTOR1_BIT];
      if (drive_swap_in) begin
         state_next.pins.drive_pick_one_low = !((sel == 2'h0) && motor0);
         state_next.pins.drive_pick_zero_low = !((sel == 2'h1) && motor1);
         state_next.pins.motor_one_low = !motor0;
         state_next.pins.motor_zero_low = !motor1;
      end else begin
         state_next.pins.drive_pick_zero_low = !((sel == 2'h0) && motor0);
         state_next.pins.drive_pick_one_low = !((sel == 2'h1) && motor1);
         state_next.pins.motor_zero_low = !motor0;
         state_next.pins.motor_one_low = !motor1;
      end

      // Code zero means no tape, so drive zero can never be flagged
      state_next.tape_hit = (state_next.tape != 2'h0) &&
                            (state_next.tape == dor_new[fdc_pkg::DOR_SEL_LSB +: 2]);

      // Tape register view; type ID follows the current select code
      type_idx = {state_reg.drive_output_control[fdc_pkg::DOR_SEL_LSB +: 2], 1'h0};
      type_id = drive_type_config_reg_in[type_idx +: 2];
      if (enhanced_floppy_mode_2_in) begin
         tdr_view = {2'h0, type_id, boot_drive_in, state_reg.tape};
      end else begin
         tdr_view = {6'h00, state_reg.tape};
      end

      // Read data stand for one cycle only; the rate register reads as status
      state_next.rdata = fdc_pkg::RDATA_IDLE;
      if (rd_dor) begin
         state_next.rdata = state_reg.drive_output_control;
      end else if (rd_tdr) begin
         state_next.rdata = tdr_view;
      end else if (rd_msr) begin
         state_next.rdata = main_status_in;
      end
   end

   // ==========================================================
   // Registers; clock enable low freezes everything
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg.drive_output_control <= fdc_pkg::DOR_RESET;
         state_reg.tape <= fdc_pkg::TAPE_RESET;
         state_reg.rate <= fdc_pkg::RATE_RESET;
         state_reg.precomp <= fdc_pkg::PRECOMP_RESET;
         state_reg.low_power <= 1'h0;
         state_reg.stretch <= 2'h0;
         state_reg.soft_reset_low <= 1'h0;
         state_reg.dma_irq_gate <= 1'h0;
         state_reg.pins <= fdc_pkg::PINS_IDLE;
         state_reg.tape_hit <= 1'h0;
         state_reg.rdata <= fdc_pkg::RDATA_IDLE;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign rd_data_out = state_reg.rdata;
   assign drive_pins_out = state_reg.pins;
   assign dma_irq_gate_out = state_reg.dma_irq_gate;
   assign soft_reset_low_out = state_reg.soft_reset_low;
   assign low_power_out = state_reg.low_power;
   assign data_rate_out = state_reg.rate;
   assign precomp_sel_out = state_reg.precomp;
   assign tape_drive_out = state_reg.tape;
   assign tape_selected_out = state_reg.tape_hit;

endmodule
`default_nettype wire

// *** hdl/fdc_pkg.sv ***
`default_nettype none
package fdc_pkg;

   // ==========================================================
   // Register addresses
   localparam int unsigned ADDR_W = 10;
   localparam logic [9:0] ADDR_DOR = 10'h3F2;
   localparam logic [9:0] ADDR_TDR = 10'h3F3;
   localparam logic [9:0] ADDR_DSR = 10'h3F4;
   localparam logic [9:0] ADDR_DATA = 10'h3F5;
   localparam logic [9:0] ADDR_CCR = 10'h3F7;

   // ==========================================================
   // Field positions
   localparam int unsigned DOR_SEL_LSB = 0;
   localparam int unsigned DOR_SOFT_RESET_LOW_BIT = 2;
   localparam int unsigned DOR_DMA_BIT = 3;
   localparam int unsigned DOR_MOTOR0_BIT = 4;
   localparam int unsigned DOR_MOTOR1_BIT = 5;
   localparam int unsigned DSR_RATE_LSB = 0;
   localparam int unsigned DSR_PRECOMP_LSB = 2;
   localparam int unsigned DSR_POWER_BIT = 6;
   localparam int unsigned DSR_SWRESET_BIT = 7;
   localparam int unsigned CCR_RATE_LSB = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] DOR_RESET = 8'h00;
   localparam logic [7:0] DSR_RESET = 8'h02;
   localparam logic [1:0] RATE_RESET = DSR_RESET[1:0];
   localparam logic [2:0] PRECOMP_RESET = DSR_RESET[4:2];
   localparam logic [1:0] TAPE_RESET = 2'h0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SOFT_RESET_MIN_NS = 100;
   localparam int unsigned SOFT_RESET_CYCLES_I =
      (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] SOFT_RESET_CYCLES = SOFT_RESET_CYCLES_I[1:0];

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      FDC_MODE_LEGACY_AT = 2'b00,
      FDC_MODE_MODEL30 = 2'b01,
      FDC_MODE_SECOND_GEN = 2'b10
   } fdc_mode_t;

   typedef struct packed {
      logic drive_pick_zero_low;
      logic drive_pick_one_low;
      logic motor_zero_low;
      logic motor_one_low;
   } fdc_drive_pins_t;

   localparam fdc_drive_pins_t PINS_IDLE = 4'hF;

   typedef struct packed {
      logic [7:0] drive_output_control;
      logic [1:0] tape;
      logic [1:0] rate;
      logic [2:0] precomp;
      logic low_power;
      logic [1:0] stretch;
      logic soft_reset_low;
      logic dma_irq_gate;
      fdc_drive_pins_t pins;
      logic tape_hit;
      logic [7:0] rdata;
   } fdc_state_t;

endpackage
`default_nettype wire

// *** testbench/fdc_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdc_regs_props (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   input wire logic [9:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rd_data_out,
   input wire fdc_pkg::fdc_mode_t mode_in,
   input wire logic enhanced_floppy_mode_2_in,
   input wire logic drive_swap_in,
   input wire logic [7:0] main_status_in,
   input wire fdc_pkg::fdc_drive_pins_t drive_pins_out,
   input wire logic dma_irq_gate_out,
   input wire logic soft_reset_low_out,
   input wire logic low_power_out,
   input wire logic [1:0] data_rate_out,
   input wire logic [2:0] precomp_sel_out,
   input wire logic [1:0] tape_drive_out
);
   // ==========
   // Decoded strobes
   logic wr_dor, wr_dsr, rd_tdr, rd_dsr;
   assign wr_dor = ce_in && wr_in && addr_in == fdc_pkg::ADDR_DOR;
   assign wr_dsr = ce_in && wr_in && addr_in == fdc_pkg::ADDR_DSR;
   assign rd_tdr = ce_in && rd_in && addr_in == fdc_pkg::ADDR_TDR;
   assign rd_dsr = ce_in && rd_in && addr_in == fdc_pkg::ADDR_DSR;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ==========
   // Properties
   sequence held_soft;
      !soft_reset_low_out [*3];
   endsequence
   a_motor_normal: assert property (wr_dor && !drive_swap_in |=>
      drive_pins_out.motor_zero_low == !$past(wr_data_in[4]) &&
      drive_pins_out.motor_one_low == !$past(wr_data_in[5])) else $error("motor line wrong");
   a_pick_normal: assert property (wr_dor && !drive_swap_in |=>
      drive_pins_out.drive_pick_zero_low == !($past(wr_data_in[1:0]) == 2'h0 &&
      $past(wr_data_in[4]))) else $error("select zero wrong");
   a_swap_motor: assert property (wr_dor && drive_swap_in |=>
      drive_pins_out.motor_one_low == !$past(wr_data_in[4])) else $error("swap wrong");
   a_gate_legacy: assert property (wr_dor && mode_in == fdc_pkg::FDC_MODE_LEGACY_AT |=>
      dma_irq_gate_out == $past(wr_data_in[3] && wr_data_in[2])) else $error("gate wrong");
   a_gate_second: assert property (ce_in && mode_in == fdc_pkg::FDC_MODE_SECOND_GEN |=>
      dma_irq_gate_out) else $error("gate off in second mode");
   a_soft_dor: assert property (wr_dor && !wr_data_in[2] |=>
      !soft_reset_low_out) else $error("soft reset missed");
   a_soft_stretch: assert property (wr_dsr && wr_data_in[7] |=> held_soft)
      else $error("soft pulse short");
   a_rate_dsr: assert property (wr_dsr |=> data_rate_out == $past(wr_data_in[1:0]) &&
      precomp_sel_out == $past(wr_data_in[4:2])) else $error("rate not taken");
   a_tdr_normal: assert property (rd_tdr && !enhanced_floppy_mode_2_in |=>
      rd_data_out == {6'h00, $past(tape_drive_out)}) else $error("tape read wrong");
   a_tdr_keep: assert property (!(ce_in && wr_in && addr_in == fdc_pkg::ADDR_TDR) |=>
      $stable(tape_drive_out)) else $error("tape changed");
   a_status_read: assert property (rd_dsr |=> rd_data_out == $past(main_status_in) &&
      !low_power_out) else $error("status read wrong");
   a_hw_rate: assert property (disable iff (1'b0) $rose(reset_n_in) |->
      data_rate_out == 2'h2 && !dma_irq_gate_out) else $error("reset rate wrong");
endmodule
bind fdc_drive_control_regs fdc_regs_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
   .rd_data_out(rd_data_out), .mode_in(mode_in),
   .enhanced_floppy_mode_2_in(enhanced_floppy_mode_2_in), .drive_swap_in(drive_swap_in),
   .main_status_in(main_status_in), .drive_pins_out(drive_pins_out),
   .dma_irq_gate_out(dma_irq_gate_out), .soft_reset_low_out(soft_reset_low_out),
   .low_power_out(low_power_out), .data_rate_out(data_rate_out),
   .precomp_sel_out(precomp_sel_out), .tape_drive_out(tape_drive_out));
`default_nettype wire

// *** testbench/fdc_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model (
   input wire logic clk_in,
   input wire fdc_pkg::fdc_drive_pins_t drive_pins_in,
   output logic spinning_out,
   output logic selected_out
);
   // One mechanism on the drive zero lines; it latches what it sees each edge
   always_ff @(posedge clk_in) begin
      spinning_out <= !drive_pins_in.motor_zero_low;
      selected_out <= !drive_pins_in.drive_pick_zero_low;
   end
endmodule
`default_nettype wire

// *** testbench/test_fdc_drive_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fdc_drive_control_regs;
   // ==========
   // Signals
   logic clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, swap = 0, enh = 0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00, rdata, got;
   fdc_pkg::fdc_mode_t mode = fdc_pkg::FDC_MODE_LEGACY_AT;
   fdc_pkg::fdc_drive_pins_t pins;
   logic gate, softn, lowp, spin, dsel, tsel;
   logic ce = 1'b1;
   logic [1:0] rate, tape;
   logic [2:0] pre;
   int mismatches = 0, check_count = 0;
   // Row: swap nibble, register value, pins nibble, gate nibble
   logic [19:0] rows [8] = '{20'h01C51, 20'h02DA1, 20'h00CF1, 20'h0F440,
      20'h0C9F0, 20'h01FD1, 20'h11CA1, 20'h12D51};
   always #20 clk_in = ~clk_in;
   fdc_drive_control_regs dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .addr_in(addr), .wr_data_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rdata),
      .mode_in(mode), .enhanced_floppy_mode_2_in(enh), .drive_swap_in(swap),
      .drive_type_config_reg_in(8'hE4), .boot_drive_in(2'h2), .main_status_in(8'h5A),
      .drive_pins_out(pins), .dma_irq_gate_out(gate), .soft_reset_low_out(softn),
      .low_power_out(lowp), .data_rate_out(rate), .precomp_sel_out(pre),
      .tape_drive_out(tape), .tape_selected_out(tsel));
   fdc_drive_model drv_u (.clk_in(clk_in), .drive_pins_in(pins), .spinning_out(spin),
      .selected_out(dsel));
   // ==========
   // Tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========
   // Sequence
   initial begin
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1;
      chk({1'b0, gate, softn, lowp, tape, rate}, 8'h02);
      chk({1'b0, pre, pins}, 8'h0F);
      foreach (rows[i]) begin
         swap <= rows[i][16];
         wr(fdc_pkg::ADDR_DOR, rows[i][15:8]);
         chk({3'h0, pins, gate}, {3'h0, rows[i][7:4], rows[i][0]});
      end
      swap <= 1'b0;
      wr(fdc_pkg::ADDR_DOR, 8'h1C);
      @(posedge clk_in);
      #1;
      chk({6'h00, spin, dsel}, 8'h03);
      for (int c = 0; c < 4; c++) begin
         wr(fdc_pkg::ADDR_TDR, {6'h3F, c[1:0]});
         rd(fdc_pkg::ADDR_TDR);
         chk(got, {6'h00, c[1:0]});
         chk({7'h00, tsel}, 8'h00);
      end
      enh <= 1'b1;
      wr(fdc_pkg::ADDR_DOR, 8'h1E);
      rd(fdc_pkg::ADDR_TDR);
      chk(got, 8'h2B);
      wr(fdc_pkg::ADDR_DOR, 8'h1F);
      rd(fdc_pkg::ADDR_TDR);
      chk(got, 8'h3B);
      chk({7'h00, tsel}, 8'h01);
      enh <= 1'b0;
      wr(fdc_pkg::ADDR_DSR, 8'h11);
      chk({1'b0, pre, 2'h0, rate}, 8'h41);
      rd(fdc_pkg::ADDR_DSR);
      chk(got, 8'h5A);
      wr(fdc_pkg::ADDR_CCR, 8'h03);
      chk({1'b0, pre, 2'h0, rate}, 8'h43);
      wr(fdc_pkg::ADDR_DOR, 8'h18);
      chk({6'h00, softn, gate}, 8'h00);
      wr(fdc_pkg::ADDR_DOR, 8'h1C);
      chk({softn, gate, tape, 1'b0, pre}, 8'hF4);
      wr(fdc_pkg::ADDR_DSR, 8'h8B);
      chk({softn, 4'h0, pre}, 8'h02);
      repeat (3) @(posedge clk_in);
      #1;
      chk({softn, 5'h00, tape}, 8'h83);
      wr(fdc_pkg::ADDR_DSR, 8'h42);
      chk({7'h00, lowp}, 8'h01);
      rd(fdc_pkg::ADDR_DSR);
      chk({7'h00, lowp}, 8'h00);
      rd(fdc_pkg::ADDR_CCR);
      chk(got, 8'h00);
      mode <= fdc_pkg::FDC_MODE_SECOND_GEN;
      wr(fdc_pkg::ADDR_DOR, 8'h14);
      chk({7'h00, gate}, 8'h01);
      rd(fdc_pkg::ADDR_DOR);
      chk(got, 8'h14);
      // Clock enable low must freeze the register and the pins
      ce <= 1'b0;
      wr(fdc_pkg::ADDR_DOR, 8'h00);
      chk({3'h0, pins, gate}, 8'h0B);
      ce <= 1'b1;
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1;
      chk({1'b0, pre, tape, rate}, 8'h02);
      rd(fdc_pkg::ADDR_DOR);
      chk(got, 8'h00);
      end_sim();
   end
   // Whole run is about 80 cycles; twenty-five times that means a hang
   initial begin
      repeat (2000) @(posedge clk_in);
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
